/* hostport_pkg.sv */
/*
 * Shared constants for the host port strap and decode block.
 * Assumes a single 10 MHz system clock and synchronous ISA-side inputs.
 */
package hostport_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DRIVE_HIGH_NS = 100;
  localparam int unsigned DRIVE_HIGH_CYC_RAW = (DRIVE_HIGH_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned DRIVE_HIGH_CYC = (DRIVE_HIGH_CYC_RAW < 1) ? 1 : DRIVE_HIGH_CYC_RAW;
  localparam logic [15:0] INTERNAL_IDX_ADDR = 16'h03E0;
  localparam logic [15:0] INTERNAL_DATA_ADDR = 16'h03E1;
  localparam logic [7:0] WINDOW_UPPER_ZERO = 8'h00;
  localparam logic [7:0] RANGE_SPAN = 8'h40;
  localparam logic [7:0] RANGE_TOP_LAST = 8'hEF;
  localparam logic [7:0] GLOBAL_CTRL_INDEX = 8'h1E;
  localparam int unsigned PWRDN_BIT = 0;
  localparam int unsigned IFSTAT_VDET_BIT = 7;
  localparam int unsigned GPI_EN_BIT = 2;
  localparam int unsigned IRQ_PULSE_CYC = 2;
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_LOW = 2'b01,
    DRV_HIGH = 2'b10
  } drive_state_t;
endpackage : hostport_pkg

/* isa_bus_model.sv */
/*
 * Host bus side of the port: pull resistors on the strap pins and on the
 * open-drain ready lines, resolving each wire from the drivers present.
 * Assumes the bench picks the strap pull levels before reset drive ends.
 */
`timescale 1ns/1ps
module isa_bus_model (
  input wire logic spk_pull_i,
  input wire logic ring_pull_i,
  input wire logic irq_pull_i,
  input wire logic spk_i,
  input wire logic spk_oe_i,
  input wire logic ring_i,
  input wire logic ring_oe_i,
  input wire logic irq_i,
  input wire logic irq_oe_i,
  input wire logic rdy_i,
  input wire logic rdy_oe_i,
  input wire logic zws_i,
  input wire logic zws_oe_i,
  output logic spk_o,
  output logic ring_o,
  output logic irq_o,
  output logic rdy_o,
  output logic zws_o
);
  // Strap resistors win only while the device leaves its pins undriven
  assign spk_o = spk_oe_i ? spk_i : spk_pull_i;
  assign ring_o = ring_oe_i ? ring_i : ring_pull_i;
  assign irq_o = irq_oe_i ? irq_i : irq_pull_i;
  // Bus pull-ups hold the ready lines once released
  assign rdy_o = rdy_oe_i ? rdy_i : 1'b1;
  assign zws_o = zws_oe_i ? zws_i : 1'b1;
endmodule : isa_bus_model

/* isa_host_port.sv */
/*
 * ISA host port of a two-slot card controller: strap capture at reset,
 * register decode, window qualification, ready drivers, voltage-detect input.
 * Assumes all ISA inputs are synchronous to clk_sys_i.
 */
// Contract
// - Speaker, ring and irq pins are inputs during reset drive; levels latched.
// - Two-strap: ring gives device bit, speaker gives slot bit, low means one.
// - One-strap: speaker low sets device bit; slots take bits zero and one.
// - Irq strap high selects internal decode, low selects external decode.
// - Internal decode: chip select low and address 03E0h or 03E1h.
// - Window access needs SA23 to SA16 all zero, never chip select.
// - Chip select level gates power-down when global control bit zero set.
// - Reset only while power-good low and reset drive high.
// - Ready lines driven high at most one clock before tri-state.
// - LA23 to LA17 are half-latched by BALE; BALE may stay high.
// - AEN high marks a DMA cycle.
// - Card memory access only while refresh is high.
// - Timing derives from the system clock.
// - Any change of the enabled general input raises an interrupt.
// - Status bit seven shows the inverted voltage-detect input.
// - In disk mode IRQ12 can drive an activity LED.
`timescale 1ns/1ps
module isa_host_port
  import hostport_pkg::*;
#(
  parameter bit TWO_STRAP = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic reset_drive_i,
  input wire logic power_ok_in_i,
  input wire logic speaker_out_strap_i,
  input wire logic ring_out_strap_i,
  input wire logic irq_out_strap_i,
  input wire logic speaker_level_i,
  input wire logic ring_level_i,
  input wire logic irq_level_i,
  output logic speaker_out_strap_o,
  output logic speaker_out_strap_oe_o,
  output logic ring_out_strap_o,
  output logic ring_out_strap_oe_o,
  output logic irq_out_strap_o,
  output logic irq_out_strap_oe_o,
  input wire logic cs_n_i,
  input wire logic [15:0] sa_i,
  input wire logic [23:16] sa_hi_i,
  input wire logic [23:17] la_i,
  input wire logic bale_i,
  input wire logic aen_i,
  input wire logic refresh_n_i,
  input wire logic ior_n_i,
  input wire logic iow_n_i,
  input wire logic memr_n_i,
  input wire logic memw_n_i,
  input wire logic [7:0] sd_i,
  input wire logic [7:0] index_i,
  input wire logic slot_sel_i,
  input wire logic pwrdn_en_i,
  input wire logic wait_req_i,
  input wire logic zero_ws_req_i,
  input wire logic voltage_detect_gp_input_i,
  input wire logic gp_input_irq_enable_i,
  input wire logic disk_interface_mode_i,
  input wire logic activity_i,
  output logic chip_reset_o,
  output logic internal_decode_o,
  output logic device_bit_o,
  output logic slot_bit_o,
  output logic reg_index_sel_o,
  output logic reg_data_sel_o,
  output logic [7:0] index_reg_o,
  output logic index_in_range_o,
  output logic io_window_ok_o,
  output logic mem_access_ok_o,
  output logic dma_cycle_o,
  output logic [23:17] la_latched_o,
  output logic power_down_o,
  output logic iochrdy_o,
  output logic iochrdy_oe_o,
  output logic zerows_n_o,
  output logic zerows_n_oe_o,
  output logic gp_irq_o,
  output logic irq12_o,
  output logic [7:0] if_status_o
);
  logic in_reset;
  logic prev_reset;
  logic cfg_device;
  logic cfg_slot;
  logic cfg_internal;
  logic gp_prev;
  logic [1:0] irq_cnt;
  logic [7:0] range_base;
  logic addr_hit;
  logic next_in_range;
  logic [23:17] next_la;

  // Reset qualifier: power-good low and reset drive high
  assign in_reset = !power_ok_in_i && reset_drive_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chip_reset_o <= 1'b1;
      prev_reset <= 1'b1;
    end else begin
      chip_reset_o <= in_reset;
      prev_reset <= in_reset;
    end
  end

  // Straps sampled while reset is held; the last value before release sticks
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_device <= 1'b0;
      cfg_slot <= 1'b0;
      cfg_internal <= 1'b1;
    end else if (in_reset) begin
      if (TWO_STRAP) begin
        cfg_device <= !ring_out_strap_i;
        cfg_slot <= !speaker_out_strap_i;
      end else begin
        cfg_device <= !speaker_out_strap_i;
        cfg_slot <= slot_sel_i;
      end
      cfg_internal <= irq_out_strap_i;
    end else if (!TWO_STRAP) begin
      cfg_slot <= slot_sel_i;
    end
  end

  // Strap pins float as inputs during reset, drive afterwards
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      speaker_out_strap_oe_o <= 1'b0;
      ring_out_strap_oe_o <= 1'b0;
      irq_out_strap_oe_o <= 1'b0;
      speaker_out_strap_o <= 1'b1;
      ring_out_strap_o <= 1'b1;
      irq_out_strap_o <= 1'b1;
    end else begin
      speaker_out_strap_oe_o <= !in_reset;
      ring_out_strap_oe_o <= !in_reset;
      irq_out_strap_oe_o <= !in_reset;
      speaker_out_strap_o <= speaker_level_i;
      ring_out_strap_o <= ring_level_i;
      irq_out_strap_o <= irq_level_i;
    end
  end

  // Control register decode; external mode relies on the system's chip select
  always_comb begin
    if (cfg_internal) begin
      addr_hit = !cs_n_i && (sa_i[15:1] == INTERNAL_IDX_ADDR[15:1]);
    end else begin
      addr_hit = !cs_n_i;
    end
  end

  assign range_base = {cfg_device, cfg_slot, 6'h00};
  assign next_in_range = (index_i >= range_base) && (index_i <= range_base + (RANGE_SPAN - 8'h01))
    && (index_i <= RANGE_TOP_LAST);

  // Index register on the low port, data on the high port
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_index_sel_o <= 1'b0;
      reg_data_sel_o <= 1'b0;
      index_reg_o <= 8'h00;
      index_in_range_o <= 1'b0;
    end else begin
      reg_index_sel_o <= addr_hit && !aen_i && !sa_i[0];
      reg_data_sel_o <= addr_hit && !aen_i && sa_i[0];
      if (addr_hit && !aen_i && !sa_i[0] && !iow_n_i) begin
        index_reg_o <= sd_i;
      end
      index_in_range_o <= next_in_range;
    end
  end

  // Latch upper address while BALE is high, hold it after
  assign next_la = bale_i ? la_i : la_latched_o;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      la_latched_o <= 7'h00;
      io_window_ok_o <= 1'b0;
      mem_access_ok_o <= 1'b0;
      dma_cycle_o <= 1'b0;
    end else begin
      la_latched_o <= next_la;
      io_window_ok_o <= (sa_hi_i == WINDOW_UPPER_ZERO) && !aen_i
        && !(ior_n_i && iow_n_i);
      mem_access_ok_o <= refresh_n_i && !aen_i && !(memr_n_i && memw_n_i);
      dma_cycle_o <= aen_i;
    end
  end

  // Power-down follows chip select when enabled in global control
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      power_down_o <= 1'b0;
    end else begin
      power_down_o <= pwrdn_en_i && cs_n_i;
    end
  end

  ready_release u_iochrdy (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .hold_low_i(wait_req_i),
    .pin_o(iochrdy_o),
    .pin_oe_o(iochrdy_oe_o)
  );

  ready_release u_zerows (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .hold_low_i(zero_ws_req_i),
    .pin_o(zerows_n_o),
    .pin_oe_o(zerows_n_oe_o)
  );

  // Change on the general input gives a fixed-width pulse counted on the clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gp_prev <= 1'b1;
      irq_cnt <= 2'h0;
      gp_irq_o <= 1'b0;
    end else begin
      gp_prev <= voltage_detect_gp_input_i;
      if (gp_input_irq_enable_i && (gp_prev != voltage_detect_gp_input_i)) begin
        irq_cnt <= 2'(IRQ_PULSE_CYC);
      end else if (irq_cnt != 2'h0) begin
        irq_cnt <= irq_cnt - 2'h1;
      end
      gp_irq_o <= (gp_input_irq_enable_i && (gp_prev != voltage_detect_gp_input_i))
        || (irq_cnt > 2'h1);
    end
  end

  // Status byte and LED use of IRQ12 in disk mode
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      if_status_o <= 8'h00;
      irq12_o <= 1'b0;
      internal_decode_o <= 1'b1;
      device_bit_o <= 1'b0;
      slot_bit_o <= 1'b0;
    end else begin
      if_status_o <= {!voltage_detect_gp_input_i, 7'h00};
      irq12_o <= disk_interface_mode_i ? activity_i : gp_irq_o;
      internal_decode_o <= cfg_internal;
      device_bit_o <= cfg_device;
      slot_bit_o <= cfg_slot;
    end
  end

  AST_STRAP_FLOAT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    in_reset |=> !speaker_out_strap_oe_o && !ring_out_strap_oe_o && !irq_out_strap_oe_o)
    else $error("strap pin driven during reset");
  AST_DECODE_MODE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    in_reset ##1 !in_reset |=> internal_decode_o == $past(irq_out_strap_i, 2))
    else $error("decode mode not taken from strap");
  AST_INT_DECODE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cfg_internal && cs_n_i) |=> !reg_index_sel_o && !reg_data_sel_o)
    else $error("register select without chip select");
  AST_WINDOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (sa_hi_i != 8'h00) |=> !io_window_ok_o)
    else $error("window access with upper address set");
  AST_RESET_QUAL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    power_ok_in_i |=> !chip_reset_o)
    else $error("reset while power good high");
  AST_REFRESH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !refresh_n_i |=> !mem_access_ok_o)
    else $error("memory access during refresh");
  AST_GP_IRQ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (gp_input_irq_enable_i && $changed(voltage_detect_gp_input_i)) |-> ##[1:2] gp_irq_o)
    else $error("no interrupt on input change");
  AST_VDET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    1'b1 |=> if_status_o[7] == !$past(voltage_detect_gp_input_i))
    else $error("status bit seven not inverted input");
  AST_LED: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    disk_interface_mode_i |=> irq12_o == $past(activity_i))
    else $error("irq12 not following activity in disk mode");
endmodule : isa_host_port

/* isa_host_port_strap_decode_tb.sv */
/*
 * Self-checking bench for the host port: straps, decode, window checks,
 * ready release, address latch, power-down and general input.
 * Assumes outputs settle one clock after inputs, strap results two.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module isa_host_port_strap_decode_tb;
  import hostport_pkg::*;
  int failures = 0;
  int checked = 0;
  logic clk_sys_i, rst_n_i, rdrv, pok, sp, rp, ip, cs_n, bale, aen, ref_n;
  logic ior_n, iow_n, memr_n, memw_n, pd_en, wreq, zreq, gpi, gpi_en, disk, act, slot;
  logic [15:0] sa;
  logic [7:0] sa_hi, sd, idx, ireg, ifs, base;
  logic [6:0] la, lal;
  logic spk_w, ring_w, irq_w, rdy_w, zws_w, so, soe, ro, roe, io, ioe, acc;
  logic creset, idec, dbit, sbit, isel, dsel, inr, iowok, memok, dma, pdn;
  logic rdy, rdy_oe, zws, zws_oe, girq, irq12, dbit1, sbit1;
  // Clock at 100 ns
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  isa_bus_model isa_bus_model_inst (.spk_pull_i(sp), .ring_pull_i(rp), .irq_pull_i(ip),
    .spk_i(so), .spk_oe_i(soe), .ring_i(ro), .ring_oe_i(roe), .irq_i(io), .irq_oe_i(ioe),
    .rdy_i(rdy), .rdy_oe_i(rdy_oe), .zws_i(zws), .zws_oe_i(zws_oe), .spk_o(spk_w),
    .ring_o(ring_w), .irq_o(irq_w), .rdy_o(rdy_w), .zws_o(zws_w));
  isa_host_port #(.TWO_STRAP(1'b1)) isa_host_port_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .reset_drive_i(rdrv), .power_ok_in_i(pok),
    .speaker_out_strap_i(spk_w), .ring_out_strap_i(ring_w), .irq_out_strap_i(irq_w),
    .speaker_level_i(1'b1), .ring_level_i(1'b0), .irq_level_i(1'b1),
    .speaker_out_strap_o(so), .speaker_out_strap_oe_o(soe), .ring_out_strap_o(ro),
    .ring_out_strap_oe_o(roe), .irq_out_strap_o(io), .irq_out_strap_oe_o(ioe),
    .cs_n_i(cs_n), .sa_i(sa), .sa_hi_i(sa_hi), .la_i(la), .bale_i(bale), .aen_i(aen),
    .refresh_n_i(ref_n), .ior_n_i(ior_n), .iow_n_i(iow_n), .memr_n_i(memr_n),
    .memw_n_i(memw_n), .sd_i(sd), .index_i(idx), .slot_sel_i(slot), .pwrdn_en_i(pd_en),
    .wait_req_i(wreq), .zero_ws_req_i(zreq), .voltage_detect_gp_input_i(gpi),
    .gp_input_irq_enable_i(gpi_en), .disk_interface_mode_i(disk), .activity_i(act),
    .chip_reset_o(creset), .internal_decode_o(idec), .device_bit_o(dbit),
    .slot_bit_o(sbit), .reg_index_sel_o(isel), .reg_data_sel_o(dsel), .index_reg_o(ireg),
    .index_in_range_o(inr), .io_window_ok_o(iowok), .mem_access_ok_o(memok),
    .dma_cycle_o(dma), .la_latched_o(lal), .power_down_o(pdn), .iochrdy_o(rdy),
    .iochrdy_oe_o(rdy_oe), .zerows_n_o(zws), .zerows_n_oe_o(zws_oe), .gp_irq_o(girq),
    .irq12_o(irq12), .if_status_o(ifs));
  // One-strap variant: straps straight from the pulls, slot bit from slot_sel_i
  isa_host_port #(.TWO_STRAP(1'b0)) isa_host_port_one_strap_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .reset_drive_i(rdrv), .power_ok_in_i(pok),
    .speaker_out_strap_i(sp), .ring_out_strap_i(rp), .irq_out_strap_i(ip),
    .speaker_level_i(1'b1), .ring_level_i(1'b0), .irq_level_i(1'b1),
    .speaker_out_strap_o(), .speaker_out_strap_oe_o(), .ring_out_strap_o(),
    .ring_out_strap_oe_o(), .irq_out_strap_o(), .irq_out_strap_oe_o(),
    .cs_n_i(cs_n), .sa_i(sa), .sa_hi_i(sa_hi), .la_i(la), .bale_i(bale), .aen_i(aen),
    .refresh_n_i(ref_n), .ior_n_i(ior_n), .iow_n_i(iow_n), .memr_n_i(memr_n),
    .memw_n_i(memw_n), .sd_i(sd), .index_i(idx), .slot_sel_i(slot), .pwrdn_en_i(pd_en),
    .wait_req_i(wreq), .zero_ws_req_i(zreq), .voltage_detect_gp_input_i(gpi),
    .gp_input_irq_enable_i(gpi_en), .disk_interface_mode_i(disk), .activity_i(act),
    .chip_reset_o(), .internal_decode_o(), .device_bit_o(dbit1),
    .slot_bit_o(sbit1), .reg_index_sel_o(), .reg_data_sel_o(), .index_reg_o(),
    .index_in_range_o(), .io_window_ok_o(), .mem_access_ok_o(),
    .dma_cycle_o(), .la_latched_o(), .power_down_o(), .iochrdy_o(),
    .iochrdy_oe_o(), .zerows_n_o(), .zerows_n_oe_o(), .gp_irq_o(),
    .irq12_o(), .if_status_o());
  // Inputs move 1 ns after the edge so the design never races the bench
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  // Reset with given strap pulls, then check the captured configuration
  task strap_case(input logic r, input logic s, input logic i);
    {rp, sp, ip, slot} = {r, s, i, i};
    {rst_n_i, rdrv, pok} = 3'b010;
    step(10);
    `CHK("strap_oe", 1'b0, soe | roe | ioe)
    `CHK("chip_reset", 1'b1, creset)
    rst_n_i = 1'b1;
    step(2);
    rdrv = 1'b0;
    step(3);
    `CHK("device_bit", ~r, dbit)
    `CHK("slot_bit", ~s, sbit)
    `CHK("int_decode", i, idec)
    `CHK("strap_oe_run", 1'b1, soe & roe & ioe)
    `CHK("chip_reset_off", 1'b0, creset)
    `CHK("strap_drive", 3'b101, {spk_w, ring_w, irq_w})
    `CHK("dev_one", ~s, dbit1)
    `CHK("slot_one", i, sbit1)
    base = {~r, ~s, 6'h00};
    idx = base;
    step(1);
    `CHK("range_lo", 1'b1, inr)
    idx = (base == 8'hC0) ? 8'hEF : base + 8'h3F;
    step(1);
    `CHK("range_hi", 1'b1, inr)
    idx = base ^ 8'h40;
    step(1);
    `CHK("range_out", 1'b0, inr)
    // F0h lies above every range, including the short top one
    idx = 8'hF0;
    step(1);
    `CHK("range_top", 1'b0, inr)
    // External decode takes any address the system selects; internal refuses 0300h
    {cs_n, sa} = {1'b0, 16'h0300};
    step(1);
    `CHK("ext_decode", ~i, isel)
    cs_n = 1'b1;
  endtask : strap_case
  // Power good high blocks reset even while reset drive is high
  task test_power_ok_in;
    {rdrv, pok} = 2'b11;
    step(2);
    `CHK("pok_blocks", 1'b0, creset)
    {rdrv, pok} = 2'b00;
    $display("done power_ok_in");
  endtask : test_power_ok_in
  // Index write then data read; SA15..SA10 stay low while chip select is low
  task test_decode;
    {cs_n, sa, iow_n, sd} = {1'b0, 16'h03E0, 1'b0, 8'hA5};
    step(1);
    `CHK("index_sel", 1'b1, isel)
    `CHK("index_reg", 8'hA5, ireg)
    {sa, iow_n, ior_n} = {16'h03E1, 1'b1, 1'b0};
    step(1);
    `CHK("data_sel", 1'b1, dsel & ~isel)
    sa = 16'h03E2;
    step(1);
    `CHK("addr_miss", 1'b0, dsel | isel)
    {sa, cs_n} = {16'h03E1, 1'b1};
    step(1);
    `CHK("cs_high", 1'b0, dsel)
    {cs_n, aen} = 2'b01;
    step(1);
    `CHK("dma_refused", 1'b0, dsel)
    {cs_n, aen, ior_n} = 3'b101;
    $display("done decode");
  endtask : test_decode
  // Window qualification by upper address, AEN and refresh
  task test_window;
    {sa, sa_hi, ior_n} = {16'h0300, 8'h00, 1'b0};
    step(1);
    `CHK("win_ok", 1'b1, iowok)
    sa_hi = 8'h01;
    step(1);
    `CHK("win_hi", 1'b0, iowok)
    {sa_hi, aen} = {8'h00, 1'b1};
    step(1);
    `CHK("win_dma", 1'b0, iowok)
    `CHK("dma", 1'b1, dma)
    {aen, ior_n, memr_n} = 3'b010;
    step(1);
    `CHK("mem_ok", 1'b1, memok)
    ref_n = 1'b0;
    step(1);
    `CHK("mem_refresh", 1'b0, memok)
    {ref_n, memr_n} = 2'b11;
    $display("done window");
  endtask : test_window
  // Address latch, power-down gating and ready release
  task test_misc;
    {bale, la} = {1'b1, 7'h55};
    step(1);
    `CHK("la_open", 7'h55, lal)
    {bale, la} = {1'b0, 7'h2A};
    step(1);
    `CHK("la_held", 7'h55, lal)
    pd_en = 1'b1;
    step(1);
    `CHK("pdn_on", 1'b1, pdn)
    cs_n = 1'b0;
    step(1);
    `CHK("pdn_cs", 1'b0, pdn)
    {pd_en, cs_n, wreq, zreq} = 4'b0111;
    step(1);
    `CHK("rdy_low", 2'b00, {rdy_w, zws_w})
    {wreq, zreq} = 2'b00;
    step(1);
    `CHK("rdy_high", 4'b1111, {rdy, rdy_oe, zws, zws_oe})
    step(1);
    `CHK("rdy_off", 2'b00, {rdy_oe, zws_oe})
    `CHK("rdy_pull", 2'b11, {rdy_w, zws_w})
    $display("done misc");
  endtask : test_misc
  // General input: status bit, enabled change interrupt, LED in disk mode
  task test_gpi;
    gpi_en = 1'b1;
    gpi = 1'b0;
    for (int t = 0; t < 4 && girq !== 1'b1; t++) step(1);
    `CHK("gp_irq", 1'b1, girq)
    `CHK("vdet_bit", 1'b1, ifs[IFSTAT_VDET_BIT])
    step(1);
    `CHK("irq12_gp", 1'b1, irq12)
    step(5);
    {gpi_en, gpi, acc} = 3'b010;
    for (int t = 0; t < 6; t++) begin
      step(1);
      acc = acc | girq;
    end
    `CHK("gp_masked", 1'b0, acc)
    `CHK("vdet_bit_hi", 1'b0, ifs[IFSTAT_VDET_BIT])
    {disk, act} = 2'b11;
    step(1);
    `CHK("led_on", 1'b1, irq12)
    act = 1'b0;
    step(1);
    `CHK("led_off", 1'b0, irq12)
    $display("done gpi");
  endtask : test_gpi
  task close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // Main sequence; the last strap case leaves internal decode, range 00h
  initial begin
    {rst_n_i, rdrv, pok, sp, rp, ip, cs_n, ref_n, ior_n, iow_n} = 10'b0100001111;
    {memr_n, memw_n, gpi, bale, aen, pd_en, wreq, zreq} = 8'b11100000;
    {gpi_en, disk, act, slot, sa, sa_hi, sd, idx, la} = '0;
    for (int k = 0; k < 8; k++) strap_case(k[2], k[1], k[0]);
    $display("done straps");
    test_power_ok_in();
    test_decode();
    test_window();
    test_misc();
    test_gpi();
    close_out();
  end
  // Whole run is under two hundred cycles; this bound cuts off a hang
  initial begin
    #200_000;
    failures++;
    close_out();
  end
endmodule : isa_host_port_strap_decode_tb

/* ready_release.sv */
/*
 * Open-drain ready line driver: pulls low on request, then on release drives
 * high for a bounded time before tri-stating.
 * Assumes the pull-up on the bus holds the line once undriven.
 */
`timescale 1ns/1ps
module ready_release
  import hostport_pkg::*;
#(
  parameter int unsigned HIGH_CYC = DRIVE_HIGH_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic hold_low_i,
  output logic pin_o,
  output logic pin_oe_o
);
  drive_state_t state;

  initial begin
    // The high drive is one fixed cycle; no other length can be served
    if (HIGH_CYC != 1) $error("HIGH_CYC must be 1");
  end

  // High drive lasts one cycle; longer would break the one-period bound
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= DRV_IDLE;
    end else begin
      case (state)
        DRV_IDLE: if (hold_low_i) state <= DRV_LOW;
        DRV_LOW: if (!hold_low_i) state <= DRV_HIGH;
        DRV_HIGH: state <= hold_low_i ? DRV_LOW : DRV_IDLE;
        default: state <= DRV_IDLE;
      endcase
    end
  end

  // Pin value from the request alone; enable from the request or the low state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b1;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o <= !(hold_low_i);
      pin_oe_o <= hold_low_i || (state == DRV_LOW);
    end
  end

  AST_HIGH_ONE_CYCLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (pin_oe_o && pin_o) |=> !(pin_oe_o && pin_o))
    else $error("ready line driven high for more than one cycle");
endmodule : ready_release
